// File: core/tocu_top.v
// Two-channel output compare unit with its 8-bit counter and an APB register slave.
// Assumes timer_tick is a one-cycle prescaler pulse on clk and the irq acks are clk-domain pulses.
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "tocu_map.vh"

// Behaviour
// - Each channel compares counter to its value; flag sets on the matching tick.
// - Interrupt request is raised while a flag and its enable are both set.
// - Executing a channel interrupt clears that channel's compare flag.
// - Writing one to a flag bit clears it; writing zero leaves it.
// - Compare values are double buffered in PWM modes, direct otherwise.
// - Buffered values move to active registers only at top or bottom.
// - Software access reaches the buffer when buffered, else the active value.
// - Force strobe in non-PWM modes acts on output only, no flag, no clear.
// - A counter write blocks compare matches on the next timer tick.
// - Output state keeps its value across waveform mode changes.
// - Output action is unbuffered and governs the next match at once.
// - Reset clears each channel's output state to zero.
// - Nonzero action replaces the general port output; direction stays with port.
// - Output state reaches the pin only while direction selects output.
// - Action zero leaves the output state unchanged at matches.
// - Counting depends on waveform mode only, never on output actions.
// - Non-PWM actions set, clear or toggle; PWM actions pick polarity.
// - Normal mode counts up only, never cleared by match, wraps to zero.
// - Normal mode sets overflow as counter becomes zero; counting never clears it.
// - Counter accepts a software write at any time in normal mode.
// - Mode 2 clears on match with channel A value as top.
// - Modes 3 and 7 are fast PWM, top max or channel A value.
// - Modes 1 and 5 are phase correct PWM, top max or channel A value.
// - Clock source zero stops the timer; software write beats count and clear.
module tocu_top #(
	parameter ADDR_W = 12
) (
	input wire clk,
	input wire resetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire timer_tick,
	input wire irq_ack_ovf,
	input wire irq_ack_a,
	input wire irq_ack_b,
	output wire irq_ovf,
	output wire irq_a,
	output wire irq_b,
	output wire pin_out_a,
	output wire pin_oe_a,
	output wire pin_out_b,
	output wire pin_oe_b
);

	// Registers
	reg [10:0] ctrl_ff;
	reg [7:0] timer_count_value_ff;
	reg count_up_ff;
	reg block_ff;
	reg [7:0] compare_value_a_ff;
	reg [7:0] compare_value_b_ff;
	reg [7:0] buf_a_ff;
	reg [7:0] buf_b_ff;
	reg overflow_flag_ff;
	reg compare_flag_a_ff;
	reg compare_flag_b_ff;
	reg [2:0] irq_en_ff;
	reg [3:0] port_ff;
	reg [31:0] prdata_ff;

	// Next values
	reg [7:0] nxt_count;
	reg nxt_count_up;
	reg nxt_ovf_event;
	reg [31:0] nxt_rdata;
	reg addr_ok;

	wire [2:0] waveform_mode_select;
	wire [1:0] output_action_select_a;
	wire [1:0] output_action_select_b;
	wire [2:0] clock_source_select;
	wire is_fast;
	wire is_pc;
	wire buffered;
	wire top_is_cmpa;
	wire [7:0] top_val;
	wire [1:0] mode_class;
	wire tick;
	wire at_top;
	wire wrap_fast;
	wire load_buf;
	wire setup;
	wire wr_acc;
	wire wr_ctrl;
	wire wr_count;
	wire wr_cmpa;
	wire wr_cmpb;
	wire wr_flags;
	wire wr_irqen;
	wire wr_force;
	wire wr_port;
	wire [1:0] match;
	wire [1:0] force_match;
	wire [1:0] oc_state;
	wire [1:0] act_nz;
	wire [1:0] act_vec [0:1];
	wire [7:0] cmp_vec [0:1];

	assign waveform_mode_select = ctrl_ff[`TOCU_CTRL_WGM];
	assign output_action_select_a = ctrl_ff[`TOCU_CTRL_ACTA];
	assign output_action_select_b = ctrl_ff[`TOCU_CTRL_ACTB];
	assign clock_source_select = ctrl_ff[`TOCU_CTRL_CS];

	// Mode decode uses waveform mode bits only
	assign is_fast = (waveform_mode_select == `TOCU_WGM_FAST_MAX) ||
		(waveform_mode_select == `TOCU_WGM_FAST_CMPA);
	assign is_pc = (waveform_mode_select == `TOCU_WGM_PC_MAX) ||
		(waveform_mode_select == `TOCU_WGM_PC_CMPA);
	assign buffered = is_fast || is_pc;
	assign top_is_cmpa = (waveform_mode_select == `TOCU_WGM_CTC) ||
		(waveform_mode_select == `TOCU_WGM_PC_CMPA) ||
		(waveform_mode_select == `TOCU_WGM_FAST_CMPA);
	assign top_val = top_is_cmpa ? compare_value_a_ff : `TOCU_CNT_MAX;
	assign mode_class = is_fast ? `TOCU_CLS_FAST : (is_pc ? `TOCU_CLS_PC : `TOCU_CLS_NONPWM);

	// Timer runs only with a clock source selected
	assign tick = timer_tick && (clock_source_select != `TOCU_CS_STOP);
	assign at_top = (timer_count_value_ff == top_val);
	assign wrap_fast = tick && is_fast && at_top;
	// Fast PWM loads at bottom, phase correct at top
	assign load_buf = tick && at_top && (is_fast || (is_pc && count_up_ff));

	// APB decode
	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pwrite;
	assign wr_ctrl = wr_acc && (paddr == `TOCU_OFF_CTRL);
	assign wr_count = wr_acc && (paddr == `TOCU_OFF_COUNT);
	assign wr_cmpa = wr_acc && (paddr == `TOCU_OFF_CMPA);
	assign wr_cmpb = wr_acc && (paddr == `TOCU_OFF_CMPB);
	assign wr_flags = wr_acc && (paddr == `TOCU_OFF_FLAGS);
	assign wr_irqen = wr_acc && (paddr == `TOCU_OFF_IRQEN);
	assign wr_force = wr_acc && (paddr == `TOCU_OFF_FORCE);
	assign wr_port = wr_acc && (paddr == `TOCU_OFF_PORT);

	always @* begin
		addr_ok = 1'b1;
		nxt_rdata = 32'h0000_0000;
		case (paddr)
		`TOCU_OFF_CTRL: nxt_rdata[10:0] = ctrl_ff;
		`TOCU_OFF_COUNT: nxt_rdata[7:0] = timer_count_value_ff;
		`TOCU_OFF_CMPA: nxt_rdata[7:0] = buffered ? buf_a_ff : compare_value_a_ff;
		`TOCU_OFF_CMPB: nxt_rdata[7:0] = buffered ? buf_b_ff : compare_value_b_ff;
		`TOCU_OFF_FLAGS: nxt_rdata[2:0] = {compare_flag_b_ff, compare_flag_a_ff,
			overflow_flag_ff};
		`TOCU_OFF_IRQEN: nxt_rdata[2:0] = irq_en_ff;
		`TOCU_OFF_FORCE: nxt_rdata = 32'h0000_0000;
		`TOCU_OFF_PORT: nxt_rdata[3:0] = port_ff;
		`TOCU_OFF_STATE: nxt_rdata[2:0] = {count_up_ff, oc_state};
		default: addr_ok = 1'b0;
		endcase
	end

	// Zero wait states; read data captured in the setup cycle
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata = prdata_ff;

	always @(posedge clk) begin
		if (!resetn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (setup) begin
			prdata_ff <= nxt_rdata;
		end
	end

	// Counter sequence
	always @* begin
		nxt_count = timer_count_value_ff;
		nxt_count_up = count_up_ff;
		nxt_ovf_event = 1'b0;
		if (tick) begin
			if (is_pc) begin
				if (count_up_ff) begin
					if (at_top) begin
						nxt_count_up = 1'b0;
						nxt_count = timer_count_value_ff - `TOCU_CNT_ONE;
					end else begin
						nxt_count = timer_count_value_ff + `TOCU_CNT_ONE;
					end
				end else if (timer_count_value_ff == `TOCU_CNT_BOTTOM) begin
					nxt_count_up = 1'b1;
					nxt_count = timer_count_value_ff + `TOCU_CNT_ONE;
					nxt_ovf_event = 1'b1;
				end else begin
					nxt_count = timer_count_value_ff - `TOCU_CNT_ONE;
				end
			end else if (is_fast) begin
				nxt_count_up = 1'b1;
				if (at_top) begin
					nxt_count = `TOCU_CNT_BOTTOM;
					nxt_ovf_event = 1'b1;
				end else begin
					nxt_count = timer_count_value_ff + `TOCU_CNT_ONE;
				end
			end else begin
				nxt_count_up = 1'b1;
				if (waveform_mode_select == `TOCU_WGM_CTC && at_top) begin
					nxt_count = `TOCU_CNT_BOTTOM;
				end else begin
					nxt_count = timer_count_value_ff + `TOCU_CNT_ONE;
				end
				if (timer_count_value_ff == `TOCU_CNT_MAX) begin
					nxt_ovf_event = 1'b1;
				end
			end
		end
		if (wr_count) begin
			nxt_count = pwdata[7:0];
		end
	end

	always @(posedge clk) begin
		if (!resetn) begin
			timer_count_value_ff <= `TOCU_CNT_BOTTOM;
			count_up_ff <= 1'b1;
			block_ff <= 1'b0;
		end else begin
			timer_count_value_ff <= nxt_count;
			count_up_ff <= nxt_count_up;
			// Block lasts until the next timer tick while a clock source is selected
			if (wr_count) begin
				block_ff <= 1'b1;
			end else if (tick) begin
				block_ff <= 1'b0;
			end
		end
	end

	// Compare values: buffer or active register per mode
	always @(posedge clk) begin
		if (!resetn) begin
			compare_value_a_ff <= `TOCU_BYTE_RST;
			compare_value_b_ff <= `TOCU_BYTE_RST;
			buf_a_ff <= `TOCU_BYTE_RST;
			buf_b_ff <= `TOCU_BYTE_RST;
		end else begin
			if (wr_cmpa && buffered) begin
				buf_a_ff <= pwdata[7:0];
			end
			if (wr_cmpb && buffered) begin
				buf_b_ff <= pwdata[7:0];
			end
			if (wr_cmpa && !buffered) begin
				compare_value_a_ff <= pwdata[7:0];
			end else if (buffered && load_buf) begin
				compare_value_a_ff <= buf_a_ff;
			end
			if (wr_cmpb && !buffered) begin
				compare_value_b_ff <= pwdata[7:0];
			end else if (buffered && load_buf) begin
				compare_value_b_ff <= buf_b_ff;
			end
		end
	end

	// Control, enables and port registers
	always @(posedge clk) begin
		if (!resetn) begin
			ctrl_ff <= `TOCU_CTRL_RST;
			irq_en_ff <= 3'h0;
			port_ff <= `TOCU_PORT_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_ff <= pwdata[10:0];
			end
			if (wr_irqen) begin
				irq_en_ff <= pwdata[2:0];
			end
			if (wr_port) begin
				port_ff <= pwdata[3:0];
			end
		end
	end

	// Flags: a hardware set in the same cycle as a clear wins
	always @(posedge clk) begin
		if (!resetn) begin
			overflow_flag_ff <= 1'b0;
			compare_flag_a_ff <= 1'b0;
			compare_flag_b_ff <= 1'b0;
		end else begin
			if (nxt_ovf_event) begin
				overflow_flag_ff <= 1'b1;
			end else if (irq_ack_ovf || (wr_flags && pwdata[`TOCU_BIT_OVF])) begin
				overflow_flag_ff <= 1'b0;
			end
			if (match[0]) begin
				compare_flag_a_ff <= 1'b1;
			end else if (irq_ack_a || (wr_flags && pwdata[`TOCU_BIT_A])) begin
				compare_flag_a_ff <= 1'b0;
			end
			if (match[1]) begin
				compare_flag_b_ff <= 1'b1;
			end else if (irq_ack_b || (wr_flags && pwdata[`TOCU_BIT_B])) begin
				compare_flag_b_ff <= 1'b0;
			end
		end
	end

	assign irq_ovf = overflow_flag_ff && irq_en_ff[`TOCU_BIT_OVF];
	assign irq_a = compare_flag_a_ff && irq_en_ff[`TOCU_BIT_A];
	assign irq_b = compare_flag_b_ff && irq_en_ff[`TOCU_BIT_B];

	assign act_vec[0] = output_action_select_a;
	assign act_vec[1] = output_action_select_b;
	assign cmp_vec[0] = compare_value_a_ff;
	assign cmp_vec[1] = compare_value_b_ff;

	// Per-channel compare, force and output state
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
			assign match[ch] = tick && !block_ff &&
				(timer_count_value_ff == cmp_vec[ch]);
			assign force_match[ch] = wr_force && pwdata[ch] && !buffered;
			assign act_nz[ch] = (act_vec[ch] != `TOCU_ACT_NONE);

			tocu_chan #(
				.CAN_TOGGLE((ch == 0) ? 1 : 0)
			) u_chan (
				.clk(clk),
				.resetn(resetn),
				.mode_class(mode_class),
				.top_is_cmpa(top_is_cmpa),
				.action(act_vec[ch]),
				.match(match[ch]),
				.force_match(force_match[ch]),
				.wrap(wrap_fast),
				.count_up(count_up_ff),
				.state(oc_state[ch])
			);
		end
	endgenerate

	// Pin override and direction
	assign pin_out_a = act_nz[0] ? oc_state[0] : port_ff[0];
	assign pin_out_b = act_nz[1] ? oc_state[1] : port_ff[1];
	assign pin_oe_a = port_ff[2];
	assign pin_oe_b = port_ff[3];

endmodule

// File: core/tocu_map.vh
// Register offsets, field positions, reset values and mode codes of the timer output compare unit.
// Included by every design file; holds definitions only.
`ifndef TOCU_MAP_VH
`define TOCU_MAP_VH

// APB byte offsets (12-bit address window)
`define TOCU_OFF_CTRL 12'h000
`define TOCU_OFF_COUNT 12'h004
`define TOCU_OFF_CMPA 12'h008
`define TOCU_OFF_CMPB 12'h00c
`define TOCU_OFF_FLAGS 12'h010
`define TOCU_OFF_IRQEN 12'h014
`define TOCU_OFF_FORCE 12'h018
`define TOCU_OFF_PORT 12'h01c
`define TOCU_OFF_STATE 12'h020

// Control register fields
`define TOCU_CTRL_WGM 2:0
`define TOCU_CTRL_ACTA 5:4
`define TOCU_CTRL_ACTB 7:6
`define TOCU_CTRL_CS 10:8
`define TOCU_CTRL_RST 11'h000

// Flag and interrupt enable bit positions
`define TOCU_BIT_OVF 0
`define TOCU_BIT_A 1
`define TOCU_BIT_B 2

// Port register fields: general outputs and pin directions
`define TOCU_PORT_OUT 1:0
`define TOCU_PORT_DIR 3:2
`define TOCU_PORT_RST 4'h0

// Waveform mode codes
`define TOCU_WGM_NORMAL 3'h0
`define TOCU_WGM_PC_MAX 3'h1
`define TOCU_WGM_CTC 3'h2
`define TOCU_WGM_FAST_MAX 3'h3
`define TOCU_WGM_PC_CMPA 3'h5
`define TOCU_WGM_FAST_CMPA 3'h7

// Mode classes seen by the channel logic
`define TOCU_CLS_NONPWM 2'h0
`define TOCU_CLS_FAST 2'h1
`define TOCU_CLS_PC 2'h2

// Output actions
`define TOCU_ACT_NONE 2'h0
`define TOCU_ACT_TOGGLE 2'h1
`define TOCU_ACT_CLEAR 2'h2
`define TOCU_ACT_SET 2'h3

// Counter extremes and reset values
`define TOCU_CNT_MAX 8'hff
`define TOCU_CNT_BOTTOM 8'h00
`define TOCU_CNT_ONE 8'h01
`define TOCU_BYTE_RST 8'h00
`define TOCU_CS_STOP 3'h0

`endif

// File: core/tocu_chan.v
// One compare channel's output state register and waveform action logic.
// Assumes match and wrap are single-cycle events on the timer tick, and force is a single-cycle APB write strobe.
`timescale 1ns/1ps
`include "tocu_map.vh"

module tocu_chan #(
	parameter CAN_TOGGLE = 1
) (
	input wire clk,
	input wire resetn,
	input wire [1:0] mode_class,
	input wire top_is_cmpa,
	input wire [1:0] action,
	input wire match,
	input wire force_match,
	input wire wrap,
	input wire count_up,
	output wire state
);

	reg state_ff;
	reg nxt_state;
	wire tog_ok;

	// Toggle in PWM classes only for the channel that may set top
	assign tog_ok = (CAN_TOGGLE != 0) && top_is_cmpa;

	always @* begin
		nxt_state = state_ff;
		case (mode_class)
		`TOCU_CLS_NONPWM: begin
			if (match || force_match) begin
				case (action)
				`TOCU_ACT_TOGGLE: nxt_state = ~state_ff;
				`TOCU_ACT_CLEAR: nxt_state = 1'b0;
				`TOCU_ACT_SET: nxt_state = 1'b1;
				default: nxt_state = state_ff;
				endcase
			end
		end
		`TOCU_CLS_FAST: begin
			if (match) begin
				case (action)
				`TOCU_ACT_TOGGLE: nxt_state = tog_ok ? ~state_ff : state_ff;
				`TOCU_ACT_CLEAR: nxt_state = 1'b0;
				`TOCU_ACT_SET: nxt_state = 1'b1;
				default: nxt_state = state_ff;
				endcase
			end
			// Bottom wins so a compare at top gives a steady level
			if (wrap) begin
				case (action)
				`TOCU_ACT_CLEAR: nxt_state = 1'b1;
				`TOCU_ACT_SET: nxt_state = 1'b0;
				default: nxt_state = nxt_state;
				endcase
			end
		end
		`TOCU_CLS_PC: begin
			if (match) begin
				case (action)
				`TOCU_ACT_TOGGLE: nxt_state = tog_ok ? ~state_ff : state_ff;
				`TOCU_ACT_CLEAR: nxt_state = ~count_up;
				`TOCU_ACT_SET: nxt_state = count_up;
				default: nxt_state = state_ff;
				endcase
			end
		end
		default: nxt_state = state_ff;
		endcase
	end

	always @(posedge clk) begin
		if (!resetn) begin
			state_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign state = state_ff;

endmodule

// File: verification/tocu_checker.sv
// Concurrent checks on the output compare unit's ports.
// Assumes APB writes land at the access edge and pready is high in every access.
`timescale 1ns/1ps
`include "tocu_map.vh"
module tocu_checker #(
	parameter ADDR_W = 12
) (
	input wire clk,
	input wire resetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire timer_tick,
	input wire irq_ack_ovf,
	input wire irq_ack_a,
	input wire irq_ack_b,
	input wire irq_ovf,
	input wire irq_a,
	input wire irq_b,
	input wire pin_out_a,
	input wire pin_oe_a,
	input wire pin_out_b,
	input wire pin_oe_b
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	wire wr = psel & penable & pwrite & pready;
	wire wr_ctrl = wr && paddr == `TOCU_OFF_CTRL;
	wire wr_cnt = wr && paddr == `TOCU_OFF_COUNT;
	wire wr_flags = wr && paddr == `TOCU_OFF_FLAGS;
	wire wr_en = wr && paddr == `TOCU_OFF_IRQEN;
	wire wr_force = wr && paddr == `TOCU_OFF_FORCE;
	wire wr_port = wr && paddr == `TOCU_OFF_PORT;
	reg [1:0] act_a_ff, pout_ff, pdir_ff;
	reg [2:0] cs_ff, wgm_ff;
	reg blk_ff;
	// Mirror of the fields the port checks depend on
	always @(posedge clk) begin
		if (!resetn) begin
			act_a_ff <= 2'h0;
			pout_ff <= 2'h0;
			pdir_ff <= 2'h0;
			cs_ff <= 3'h0;
			wgm_ff <= 3'h0;
			blk_ff <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				act_a_ff <= pwdata[5:4];
				cs_ff <= pwdata[10:8];
				wgm_ff <= pwdata[2:0];
			end
			if (wr_port) begin
				pout_ff <= pwdata[1:0];
				pdir_ff <= pwdata[3:2];
			end
			if (wr_cnt)
				blk_ff <= 1'b1;
			else if (timer_tick && cs_ff != `TOCU_CS_STOP)
				blk_ff <= 1'b0;
		end
	end
	property p_ack;
		irq_ack_a && !timer_tick |=> !irq_a;
	endproperty
	a_ack: assert property (p_ack) else $error("ack did not clear flag a");
	property p_w1c;
		wr_flags && pwdata[`TOCU_BIT_A] && !timer_tick |=> !irq_a;
	endproperty
	a_w1c: assert property (p_w1c) else $error("write one did not clear flag a");
	property p_src;
		$rose(irq_a) |-> $past(timer_tick) || $past(wr_en);
	endproperty
	a_src: assert property (p_src) else $error("irq a rose without a tick");
	property p_block;
		timer_tick && blk_ff && cs_ff != 3'h0 && !wr_en && !wr_cnt
			|=> !$rose(irq_a) && !$rose(irq_b);
	endproperty
	a_block: assert property (p_block) else $error("match after count write");
	property p_stop;
		cs_ff == `TOCU_CS_STOP && !wr_en |=> !$rose(irq_a) && !$rose(irq_b) && !$rose(irq_ovf);
	endproperty
	a_stop: assert property (p_stop) else $error("flag set while stopped");
	property p_port;
		act_a_ff == `TOCU_ACT_NONE |-> pin_out_a == pout_ff[0];
	endproperty
	a_port: assert property (p_port) else $error("pin a not port output");
	property p_dir;
		pin_oe_a == pdir_ff[0] && pin_oe_b == pdir_ff[1];
	endproperty
	a_dir: assert property (p_dir) else $error("pin enable not direction bit");
	property p_force;
		wr_force && pwdata[0] && !timer_tick && wgm_ff == `TOCU_WGM_NORMAL
			&& act_a_ff == `TOCU_ACT_SET |=> pin_out_a && !$rose(irq_a);
	endproperty
	a_force: assert property (p_force) else $error("force set failed");
	property p_rst;
		$rose(resetn) |-> !irq_a && !irq_b && !irq_ovf && !pin_out_a && !pin_oe_a;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not clear after reset");
	c_irq: cover property ($rose(irq_a));
	c_force: cover property (wr_force && act_a_ff == `TOCU_ACT_SET);
	c_block: cover property (timer_tick && blk_ff && cs_ff != 3'h0);
endmodule
bind tocu_top tocu_checker #(.ADDR_W(ADDR_W)) u_tocu_checker (.clk(clk), .resetn(resetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_tick(timer_tick),
	.irq_ack_ovf(irq_ack_ovf), .irq_ack_a(irq_ack_a), .irq_ack_b(irq_ack_b),
	.irq_ovf(irq_ovf), .irq_a(irq_a), .irq_b(irq_b), .pin_out_a(pin_out_a),
	.pin_oe_a(pin_oe_a), .pin_out_b(pin_out_b), .pin_oe_b(pin_oe_b));

// File: verification/tocu_load.sv
// Load on a compare output pin: resolves the level seen off chip.
// Assumes a pin without pull resistor; released pin shows the inverse of the last level.
`timescale 1ns/1ps
module tocu_load (
	input wire logic clk,
	input wire logic pin_out,
	input wire logic pin_oe,
	output logic pin_level
);
	logic last_ff = 1'b0;
	always @(posedge clk) begin
		if (pin_oe)
			last_ff <= pin_out;
	end
	assign pin_level = pin_oe ? pin_out : ~last_ff;
endmodule

// File: verification/tb.sv
// Self-checking bench for the output compare unit, driven over APB.
// Assumes a zero-wait APB slave and a one-cycle timer_tick pulse per timer clock.
`timescale 1ns/1ps
`include "tocu_map.vh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin num_errors++; \
	$display("mismatch %s exp %h got %h", nm, ex, got); end end
module tb;
	logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, timer_tick = 0;
	logic ack_a = 0, ack_b = 0, ack_ovf = 0, serr;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, rd;
	wire [31:0] prdata;
	wire pready, pslverr, irq_ovf, irq_a, irq_b, out_a, oe_a, out_b, oe_b, lvl_a;
	int num_errors = 0, samples_checked = 0;
	logic [1:0] acts [3] = '{2'h3, 2'h2, 2'h1};
	logic exps [3] = '{1'b1, 1'b0, 1'b1};
	initial forever #2 clk = ~clk;
	tocu_top u_tocu_top (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer_tick(timer_tick), .irq_ack_ovf(ack_ovf), .irq_ack_a(ack_a),
		.irq_ack_b(ack_b), .irq_ovf(irq_ovf), .irq_a(irq_a), .irq_b(irq_b), .pin_out_a(out_a),
		.pin_oe_a(oe_a), .pin_out_b(out_b), .pin_oe_b(oe_b));
	tocu_load u_tocu_load (.clk(clk), .pin_out(out_a), .pin_oe(oe_a), .pin_level(lvl_a));
	task wrap_up;
		if (num_errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			n++;
			if (n > 20) begin
				num_errors++;
				wrap_up();
			end
			@(posedge clk);
		end
		rd = prdata;
		serr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rchk(input logic [11:0] a, input logic [31:0] ex, input string nm);
		apb(1'b0, a, 32'h0);
		`CHK(nm, ex, rd)
	endtask
	task tick(input int n);
		repeat (n) begin
			@(posedge clk);
			timer_tick <= 1;
			@(posedge clk);
			timer_tick <= 0;
		end
	endtask
	// Count 2, blocked tick to 3, matching tick at 3
	task hit;
		wr(`TOCU_OFF_COUNT, 32'h2);
		tick(2);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1;
		rchk(`TOCU_OFF_STATE, 32'h4, "state_rst");
		apb(1'b0, 12'hffc, 32'h0);
		`CHK("slverr", 1'b1, serr)
		`CHK("unmapped", 32'h0, rd)
		wr(`TOCU_OFF_IRQEN, 32'h7);
		wr(`TOCU_OFF_CMPA, 32'h3);
		wr(`TOCU_OFF_CTRL, 32'h110);
		hit();
		@(negedge clk);
		`CHK("irq_a", 1'b1, irq_a)
		rchk(`TOCU_OFF_STATE, 32'h5, "toggle");
		rchk(`TOCU_OFF_COUNT, 32'h4, "count_up");
		wr(`TOCU_OFF_FLAGS, 32'h0);
		rchk(`TOCU_OFF_FLAGS, 32'h2, "flag_kept");
		wr(`TOCU_OFF_FLAGS, 32'h2);
		rchk(`TOCU_OFF_FLAGS, 32'h0, "flag_w1c");
		wr(`TOCU_OFF_COUNT, 32'h3);
		tick(1);
		rchk(`TOCU_OFF_FLAGS, 32'h0, "blocked");
		wr(`TOCU_OFF_CTRL, 32'h100);
		hit();
		rchk(`TOCU_OFF_STATE, 32'h5, "no_action");
		wr(`TOCU_OFF_CTRL, 32'h120);
		hit();
		rchk(`TOCU_OFF_STATE, 32'h4, "clear_now");
		@(posedge clk);
		ack_a <= 1;
		@(posedge clk);
		ack_a <= 0;
		@(negedge clk);
		`CHK("ack_a", 1'b0, irq_a)
		wr(`TOCU_OFF_COUNT, 32'hfe);
		tick(2);
		rchk(`TOCU_OFF_FLAGS, 32'h1, "overflow");
		rchk(`TOCU_OFF_COUNT, 32'h0, "wrap");
		`CHK("irq_ovf", 1'b1, irq_ovf)
		wr(`TOCU_OFF_CTRL, 32'h0);
		wr(`TOCU_OFF_COUNT, 32'h7);
		tick(3);
		rchk(`TOCU_OFF_COUNT, 32'h7, "stopped");
		wr(`TOCU_OFF_PORT, 32'h5);
		@(negedge clk);
		`CHK("port_out", 1'b1, lvl_a)
		for (int i = 0; i < 3; i++) begin
			wr(`TOCU_OFF_CTRL, {26'h0, acts[i], 4'h0});
			wr(`TOCU_OFF_FORCE, 32'h1);
			@(negedge clk);
			`CHK("force", exps[i], lvl_a)
		end
		rchk(`TOCU_OFF_FLAGS, 32'h1, "force_noflag");
		wr(`TOCU_OFF_CTRL, 32'h23);
		wr(`TOCU_OFF_FORCE, 32'h1);
		wr(`TOCU_OFF_CTRL, 32'h10);
		rchk(`TOCU_OFF_STATE, 32'h5, "mode_keep");
		wr(`TOCU_OFF_PORT, 32'h1);
		@(negedge clk);
		`CHK("oe_off", 1'b0, oe_a)
		`CHK("lvl_off", 1'b0, lvl_a)
		wr(`TOCU_OFF_CMPB, 32'h20);
		wr(`TOCU_OFF_CTRL, 32'h103);
		wr(`TOCU_OFF_CMPB, 32'h5);
		rchk(`TOCU_OFF_CMPB, 32'h5, "buf_read");
		wr(`TOCU_OFF_COUNT, 32'h4);
		tick(2);
		rchk(`TOCU_OFF_FLAGS, 32'h1, "buffered");
		wr(`TOCU_OFF_COUNT, 32'hfe);
		tick(2);
		wr(`TOCU_OFF_COUNT, 32'h4);
		tick(2);
		rchk(`TOCU_OFF_FLAGS, 32'h5, "loaded");
		`CHK("irq_b", 1'b1, irq_b)
		// Non-inverted fast PWM on channel B: set at bottom, clear at match
		wr(`TOCU_OFF_CTRL, 32'h183);
		wr(`TOCU_OFF_COUNT, 32'hfe);
		tick(2);
		@(negedge clk);
		`CHK("pwm_bottom", 1'b1, out_b)
		wr(`TOCU_OFF_COUNT, 32'h4);
		tick(2);
		rchk(`TOCU_OFF_STATE, 32'h5, "pwm_match");
		@(posedge clk);
		ack_b <= 1;
		ack_ovf <= 1;
		@(posedge clk);
		ack_b <= 0;
		ack_ovf <= 0;
		@(negedge clk);
		`CHK("ack_b", 1'b0, irq_b)
		`CHK("ack_ovf", 1'b0, irq_ovf)
		// Clear on match with channel A as top
		wr(`TOCU_OFF_CTRL, 32'h102);
		wr(`TOCU_OFF_CMPA, 32'h4);
		wr(`TOCU_OFF_COUNT, 32'h3);
		tick(2);
		rchk(`TOCU_OFF_COUNT, 32'h0, "ctc_clear");
		rchk(`TOCU_OFF_FLAGS, 32'h2, "ctc_flag");
		// Phase correct turns down at max
		wr(`TOCU_OFF_CTRL, 32'h101);
		wr(`TOCU_OFF_COUNT, 32'hfe);
		tick(3);
		rchk(`TOCU_OFF_COUNT, 32'hfd, "pc_down");
		rchk(`TOCU_OFF_STATE, 32'h1, "pc_dir");
		wrap_up();
	end
endmodule
